// File: core/dfm_core.sv
// Diagnostic supervision: temperature and supply flags, fault line, monitor ADC control.
// Assumes register writes and reads arrive decoded from the serial frame engine,
// and that all comparator and fault inputs are synchronous to clk.
`timescale 1ns/1ps
`include "dfm_consts.svh"
module dfm_core (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register write port
  input wire logic reg_wr_en,
  input wire dfm_pkg::dfm_addr_t reg_wr_addr,
  input wire dfm_pkg::dfm_data_t reg_wr_data,
  // Register read port, plus mirror and status outputs
  input wire logic reg_rd_en,
  input wire dfm_pkg::dfm_addr_t reg_rd_addr,
  output dfm_pkg::dfm_data_t reg_rd_data,
  output logic fault_line_mirror,
  output logic [23:0] status_word,
  // Comparators
  input wire logic [3:0] temp_over_level,
  input wire logic ref_input_bad,
  input wire logic ref_output_bad,
  input wire logic regulator_bad,
  input wire logic supply_bad,
  // Output stage faults
  input wire logic open_circuit_fault,
  input wire logic short_circuit_fault,
  // Digital fault flags
  input wire logic [11:0] digital_flags,
  // Fault line pin
  input wire logic fault_line_n_i,
  output logic fault_line_n_o,
  output logic fault_line_n_oe,
  // Monitor ADC
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [4:0] adc_mux_sel
);
  import dfm_pkg::*;

  // ==========================================================
  // Reset release through two flops
  logic rst_s1_reg;
  logic rst_n_sync;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n_sync <= rst_s1_reg;
    end
  end

  // ==========================================================
  // Configuration registers
  dfm_data_t gs1_reg, gs1_next;
  dfm_data_t gs2_reg, gs2_next;
  dfm_data_t mask_reg, mask_next;
  dfm_data_t osu_reg, osu_next;
  logic [10:0] adc_ctrl_reg, adc_ctrl_next;
  logic start_req;
  logic [6:0] af_clr;

  // Write decode, plus the clear strobes and conversion start
  always_comb
  begin
    gs1_next = gs1_reg;
    gs2_next = gs2_reg;
    mask_next = mask_reg;
    osu_next = osu_reg;
    adc_ctrl_next = adc_ctrl_reg;
    start_req = 1'b0;
    af_clr = 7'h00;
    if (reg_wr_en)
    begin
      if (dfm_hit(reg_wr_addr, `DFM_OFS_GEN_SETUP_ONE))
        gs1_next = reg_wr_data;
      else if (dfm_hit(reg_wr_addr, `DFM_OFS_GEN_SETUP_TWO))
        gs2_next = reg_wr_data;
      else if (dfm_hit(reg_wr_addr, `DFM_OFS_FAULT_MASK))
        mask_next = reg_wr_data;
      else if (dfm_hit(reg_wr_addr, `DFM_OFS_OUTPUT_SETUP))
        osu_next = reg_wr_data;
      else if (dfm_hit(reg_wr_addr, `DFM_OFS_ANALOG_FLAGS))
        af_clr = reg_wr_data[6:0];
      else if (dfm_hit(reg_wr_addr, `DFM_OFS_ADC_CTRL))
      begin
        adc_ctrl_next = reg_wr_data[10:0];
        // Only the keyed pattern starts a conversion
        start_req = (reg_wr_data[10:5] == `DFM_ADC_KEY);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      gs1_reg <= `DFM_RST_GS1;
      gs2_reg <= `DFM_RST_GS2;
      mask_reg <= `DFM_RST_MASK;
      osu_reg <= `DFM_RST_OSU;
      adc_ctrl_reg <= 11'(`DFM_RST_ADC);
    end
    else
    begin
      gs1_reg <= gs1_next;
      gs2_reg <= gs2_next;
      mask_reg <= mask_next;
      osu_reg <= osu_next;
      adc_ctrl_reg <= adc_ctrl_next;
    end
  end

  // ==========================================================
  // Background comparators feeding the analog flags
  logic [1:0] trip_sel;
  logic temp_hit;
  logic sup_on;
  logic refbuf_on;
  logic [6:0] af_set;
  logic [6:0] af;

  // Trip level chosen by field; no enable on temperature
  assign trip_sel = gs1_reg[`DFM_GS1_TRIP_LSB +: 2];
  assign temp_hit = temp_over_level[trip_sel];
  // Supply comparators idle until software enables them
  assign sup_on = |gs2_reg[`DFM_GS2_SUPMON_LSB +: 2];
  assign refbuf_on = osu_reg[`DFM_OSU_REFBUF_BIT];

  // Each node has its own set term; they are independent so a
  // reference-output fault raises only its own flag, never the dependants
  always_comb
  begin
    af_set = 7'h00;
    af_set[`DFM_AF_OPEN] = open_circuit_fault;
    af_set[`DFM_AF_SHORT] = short_circuit_fault;
    af_set[`DFM_AF_TEMP] = temp_hit;
    af_set[`DFM_AF_REFERENCE_OUTPUT_NODE] = sup_on & ref_output_bad;
    af_set[`DFM_AF_REFERENCE_INPUT_NODE] = sup_on & refbuf_on & ref_input_bad;
    af_set[`DFM_AF_SUPPLY] = sup_on & supply_bad;
    af_set[`DFM_AF_REGUL] = sup_on & regulator_bad;
  end

  dfm_flag_bank #(
    .W(7)
  ) u_flags (
    .clk(clk),
    .rst_n(rst_n_sync),
    .set_in(af_set),
    .clr_in(af_clr),
    .flags(af)
  );

  // ==========================================================
  // Fault line aggregation
  logic dig_drive;
  logic ana_drive;
  logic line_drive;

  // Digital sources; unrefreshed, reset and slew never reach the pin
  always_comb
  begin
    dig_drive = 1'b0;
    dig_drive |= digital_flags[`DFM_DF_OSC] & ~mask_reg[0];
    dig_drive |= digital_flags[`DFM_DF_WDT] & ~mask_reg[1];
    dig_drive |= digital_flags[`DFM_DF_LATCH] & ~mask_reg[2];
    dig_drive |= digital_flags[`DFM_DF_INVERSE] & ~mask_reg[3];
    dig_drive |= digital_flags[`DFM_DF_INVALID] & ~mask_reg[4];
    dig_drive |= digital_flags[`DFM_DF_SLIP] & ~mask_reg[5];
    dig_drive |= digital_flags[`DFM_DF_SPICRC] & ~mask_reg[6];
    dig_drive |= digital_flags[`DFM_DF_CALCRC];
    // Clock-count error has no mask, only the quiet bit
    dig_drive |= digital_flags[`DFM_DF_SCLK] & ~gs1_reg[`DFM_GS1_QUIET_BIT];
  end

  // Analog sources; reference and supply comparator errors cannot be masked
  always_comb
  begin
    ana_drive = 1'b0;
    ana_drive |= af[`DFM_AF_OPEN] & ~mask_reg[7];
    ana_drive |= af[`DFM_AF_SHORT] & ~mask_reg[8];
    ana_drive |= af[`DFM_AF_TEMP] & ~mask_reg[9];
    ana_drive |= af[`DFM_AF_REFERENCE_OUTPUT_NODE] | af[`DFM_AF_REFERENCE_INPUT_NODE];
    ana_drive |= af[`DFM_AF_SUPPLY] | af[`DFM_AF_REGUL];
  end

  assign line_drive = dig_drive | ana_drive;

  // ==========================================================
  // Monitor ADC sequencer
  logic busy;
  logic [11:0] result;
  logic [4:0] result_ch;

  dfm_adc_seq u_adc (
    .clk(clk),
    .rst_n(rst_n_sync),
    .start_req(start_req),
    .sel_in(reg_wr_data[`DFM_ADC_SEL_LSB +: 5]),
    .adc_data(adc_data),
    .adc_start(adc_start),
    .adc_mux_sel(adc_mux_sel),
    .busy(busy),
    .result(result),
    .result_ch(result_ch)
  );

  // ==========================================================
  // Pin, status word and readback
  logic oe_reg, oe_next;
  logic mirror_reg, mirror_next;
  logic [23:0] status_reg, status_next;
  dfm_data_t rd_reg, rd_next;
  logic dig_sum;
  logic ana_sum;

  // Digital summary follows the flags directly; the analog summary ORs the sticky flags
  assign dig_sum = |digital_flags[`DFM_DF_SPICRC:0];
  assign ana_sum = |af;

  always_comb
  begin
    // Open-drain: only ever drive low, enable means pulling
    oe_next = line_drive;
    // Mirror the real pin, which another device may also pull
    mirror_next = ~fault_line_n_i;
    status_next = {2'b10, mirror_reg, dig_sum, ana_sum,
                   digital_flags[`DFM_DF_WDT], busy, result_ch, result};
    rd_next = rd_reg;
    if (reg_rd_en)
    begin
      if (dfm_hit(reg_rd_addr, `DFM_OFS_GEN_SETUP_ONE))
        rd_next = gs1_reg;
      else if (dfm_hit(reg_rd_addr, `DFM_OFS_GEN_SETUP_TWO))
        rd_next = gs2_reg;
      else if (dfm_hit(reg_rd_addr, `DFM_OFS_FAULT_MASK))
        rd_next = mask_reg;
      else if (dfm_hit(reg_rd_addr, `DFM_OFS_OUTPUT_SETUP))
        rd_next = osu_reg;
      else if (dfm_hit(reg_rd_addr, `DFM_OFS_ANALOG_FLAGS))
        rd_next = {9'h000, af};
      else if (dfm_hit(reg_rd_addr, `DFM_OFS_ADC_CTRL))
        rd_next = {5'h00, adc_ctrl_reg};
      else if (dfm_hit(reg_rd_addr, `DFM_OFS_STATUS))
        rd_next = status_reg[15:0];
      else
        rd_next = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      oe_reg <= 1'b0;
      mirror_reg <= 1'b0;
      status_reg <= 24'h800000;
      rd_reg <= 16'h0000;
    end
    else
    begin
      oe_reg <= oe_next;
      mirror_reg <= mirror_next;
      status_reg <= status_next;
      rd_reg <= rd_next;
    end
  end

  // Output drivers straight from flops; the pin data is a constant low
  assign fault_line_n_oe = oe_reg;
  assign fault_line_n_o = 1'b0 & oe_reg;
  assign fault_line_mirror = mirror_reg;
  assign status_word = status_reg;
  assign reg_rd_data = rd_reg;

endmodule

// File: core/dfm_consts.svh
// Constants of the diagnostic fault and monitor ADC block.
// Assumes a 125 MHz core clock and a 5-bit register address from the frame engine.
`ifndef DFM_CONSTS_SVH
`define DFM_CONSTS_SVH

// ==========================================================
// Register offsets
`define DFM_OFS_GEN_SETUP_ONE 5'h02
`define DFM_OFS_GEN_SETUP_TWO 5'h03
`define DFM_OFS_FAULT_MASK 5'h04
`define DFM_OFS_OUTPUT_SETUP 5'h05
`define DFM_OFS_ANALOG_FLAGS 5'h06
`define DFM_OFS_ADC_CTRL 5'h07
`define DFM_OFS_STATUS 5'h08

// ==========================================================
// Field positions
`define DFM_GS1_TRIP_LSB 0
`define DFM_GS1_QUIET_BIT 3
`define DFM_GS2_SUPMON_LSB 0
`define DFM_OSU_REFBUF_BIT 0
`define DFM_ADC_SEL_LSB 0
`define DFM_ADC_KEY_LSB 5
`define DFM_ADC_KEY 6'h20

// Analog flag positions
`define DFM_AF_OPEN 0
`define DFM_AF_SHORT 1
`define DFM_AF_TEMP 2
`define DFM_AF_REFERENCE_OUTPUT_NODE 3
`define DFM_AF_REFERENCE_INPUT_NODE 4
`define DFM_AF_SUPPLY 5
`define DFM_AF_REGUL 6

// Digital flag positions
`define DFM_DF_OSC 0
`define DFM_DF_UNREF 1
`define DFM_DF_RESET 2
`define DFM_DF_WDT 3
`define DFM_DF_LATCH 4
`define DFM_DF_INVERSE 5
`define DFM_DF_CALCRC 6
`define DFM_DF_INVALID 7
`define DFM_DF_SCLK 8
`define DFM_DF_SLIP 9
`define DFM_DF_SPICRC 10
`define DFM_DF_SLEW 11

// ==========================================================
// Reset values
`define DFM_RST_GS1 16'h0000
`define DFM_RST_GS2 16'h0000
`define DFM_RST_MASK 16'h0000
`define DFM_RST_OSU 16'h0000
`define DFM_RST_ADC 16'h0000

// ==========================================================
// Timing
`define DFM_CLK_HZ 125000000
`define DFM_ADC_CONV_NS 2000
`define DFM_ADC_CONV_CYC ((`DFM_ADC_CONV_NS * (`DFM_CLK_HZ / 1000000) + 999) / 1000)

`endif

// File: core/dfm_pkg.sv
// Types shared by the diagnostic fault and monitor ADC block.
// Assumes dfm_consts.svh is available on the include path.
package dfm_pkg;

  // ==========================================================
  // Types
  typedef enum logic {DFM_ADC_IDLE, DFM_ADC_CONV} dfm_adc_state_t;
  typedef logic [4:0] dfm_addr_t;
  typedef logic [15:0] dfm_data_t;

  // Address match, used by every register decode
  function automatic logic dfm_hit(input dfm_addr_t a, input dfm_addr_t ofs);
    dfm_hit = (a == ofs);
  endfunction

endpackage

// File: core/dfm_flag_bank.sv
// Sticky write-1-to-clear flag bank.
// Assumes set inputs are synchronous levels; the clear is a one-cycle strobe.
`timescale 1ns/1ps
module dfm_flag_bank #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Flag control
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] flags
);

  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // ==========================================================
  // Set beats clear, so a persisting fault keeps its flag
  always_comb
  begin
    flags_next = (flags_reg & ~clr_in) | set_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  assign flags = flags_reg;

endmodule

// File: core/dfm_adc_seq.sv
// Single-shot conversion sequencer of the monitoring ADC.
// Assumes the converter presents its result on adc_data when the latency ends.
`timescale 1ns/1ps
`include "dfm_consts.svh"
module dfm_adc_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic start_req,
  input wire logic [4:0] sel_in,
  // Converter
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [4:0] adc_mux_sel,
  // Result
  output logic busy,
  output logic [11:0] result,
  output logic [4:0] result_ch
);
  import dfm_pkg::*;

  localparam logic [15:0] CONV_CYC = 16'(`DFM_ADC_CONV_CYC);

  dfm_adc_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic start_reg, start_next;
  logic [4:0] sel_reg, sel_next;
  logic [11:0] res_reg, res_next;
  logic [4:0] ch_reg, ch_next;

  // ==========================================================
  // Starts while busy are dropped: no queue, no restart
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    start_next = 1'b0;
    sel_next = sel_reg;
    res_next = res_reg;
    ch_next = ch_reg;
    case (state_reg)
      DFM_ADC_IDLE:
      begin
        if (start_req)
        begin
          state_next = DFM_ADC_CONV;
          start_next = 1'b1;
          // Every code reaches the mux; reserved ones convert as they are
          sel_next = sel_in;
          cnt_next = CONV_CYC - 16'h0001;
        end
      end
      DFM_ADC_CONV:
      begin
        // start_req ignored here
        if (cnt_reg == 16'h0000)
        begin
          state_next = DFM_ADC_IDLE;
          res_next = adc_data;
          ch_next = sel_reg;
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      default: state_next = DFM_ADC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= DFM_ADC_IDLE;
      cnt_reg <= 16'h0000;
      start_reg <= 1'b0;
      sel_reg <= 5'h00;
      res_reg <= 12'h000;
      ch_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      start_reg <= start_next;
      sel_reg <= sel_next;
      res_reg <= res_next;
      ch_reg <= ch_next;
    end
  end

  assign busy = (state_reg == DFM_ADC_CONV);
  assign adc_start = start_reg;
  assign adc_mux_sel = sel_reg;
  assign result = res_reg;
  assign result_ch = ch_reg;

endmodule

// File: tb/dfm_core_monitor.sv
// Port-level assertions for the diagnostic block.
// Assumes one clk domain; nrst resets it.
`timescale 1ns/1ps
module dfm_core_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register writes
  input wire logic reg_wr_en,
  input wire dfm_pkg::dfm_addr_t reg_wr_addr,
  input wire dfm_pkg::dfm_data_t reg_wr_data,
  // Watched outputs and pins
  input wire logic fault_line_mirror,
  input wire logic [23:0] status_word,
  input wire logic [11:0] digital_flags,
  input wire logic fault_line_n_i,
  input wire logic fault_line_n_o,
  input wire logic fault_line_n_oe,
  input wire logic adc_start,
  input wire logic [4:0] adc_mux_sel
);
  import dfm_pkg::*;
  // ==========================================
  // Settling count
  logic [2:0] up_reg;
  logic [2:0] up_next;
  logic ok;
  logic go;
  // Internal reset trails nrst by two edges
  always_comb
  begin
    up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      up_reg <= 3'h0;
    else
      up_reg <= up_next;
  end
  assign ok = (up_reg == 3'h7);
  assign go = reg_wr_en && (reg_wr_addr == 5'h07) && (reg_wr_data[10:5] == 6'h20);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Converter control
  a_start_on_key: assert property (ok && go && !status_word[17] && !adc_start |=> adc_start)
    else $error("keyed write gave no start");
  a_bad_key_quiet: assert property (reg_wr_en && reg_wr_addr == 5'h07 && !go |=> !adc_start)
    else $error("start without key");
  a_start_once: assert property (adc_start |=> !adc_start)
    else $error("start pulse too long");
  a_busy_follows: assert property (adc_start |=> status_word[17])
    else $error("busy missing after start");
  a_no_start_busy: assert property (status_word[17] |-> !adc_start)
    else $error("start while busy");
  a_busy_length: assert property ($rose(status_word[17]) |-> ##[248:252] $fell(status_word[17]))
    else $error("busy length wrong");
  a_mux_sel_taken: assert property (adc_start |-> adc_mux_sel == $past(reg_wr_data[4:0]))
    else $error("mux select differs");
  // ==========================================
  // Fault line and status
  a_mirror_inverts: assert property (ok |-> fault_line_mirror == !$past(fault_line_n_i))
    else $error("mirror not inverse");
  a_drain_only: assert property (fault_line_n_o == 1'b0)
    else $error("line driven high");
  a_calcrc_drives: assert property (ok && digital_flags[6] |=> fault_line_n_oe)
    else $error("unmaskable fault not on line");
  a_status_head: assert property (status_word[23:22] == 2'b10)
    else $error("status header wrong");
  a_status_mirror: assert property (ok |-> status_word[21] == $past(fault_line_mirror))
    else $error("status mirror wrong");
  a_summary_or: assert property (ok && digital_flags == $past(digital_flags) |=>
    status_word[20] == |$past(digital_flags[10:0]) && status_word[18] == $past(digital_flags[3]))
    else $error("summary bits wrong");
endmodule
bind dfm_core dfm_core_monitor i_mon (.clk(clk), .nrst(nrst), .reg_wr_en(reg_wr_en),
  .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .fault_line_mirror(fault_line_mirror),
  .status_word(status_word), .digital_flags(digital_flags), .fault_line_n_i(fault_line_n_i),
  .fault_line_n_o(fault_line_n_o), .fault_line_n_oe(fault_line_n_oe), .adc_start(adc_start),
  .adc_mux_sel(adc_mux_sel));

// File: tb/dfm_far_model.sv
// Far side: shared pulled-up fault line and the converter.
// Assumes the bench holds code_in steady through a conversion.
`timescale 1ns/1ps
module dfm_far_model (
  // Fault line
  input wire logic dut_pull,
  input wire logic other_pull,
  output logic fault_line_n,
  // Converter
  input wire logic [4:0] adc_mux_sel,
  input wire logic [11:0] code_in,
  output logic [11:0] adc_data
);
  // Pull-up wins unless some party sinks the line
  assign fault_line_n = (dut_pull || other_pull) ? 1'b0 : 1'b1;
  // Sample value tied to the channel, so a wrong channel shows
  assign adc_data = code_in ^ {adc_mux_sel, 7'h00};
endmodule

// File: tb/dfm_core_tb.sv
// Self-checking bench for the diagnostic block.
// Assumes the far model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module dfm_core_tb;
  import dfm_pkg::*;
  logic clk, nrst, reg_wr_en, reg_rd_en, ref_input_bad, ref_output_bad, regulator_bad, supply_bad;
  logic open_circuit_fault, short_circuit_fault, fault_line_n, other_pull, fault_line_n_o;
  logic fault_line_n_oe, fault_line_mirror, adc_start, rd_d, busy_d;
  dfm_addr_t reg_wr_addr, reg_rd_addr;
  dfm_data_t reg_wr_data, reg_rd_data;
  logic [23:0] status_word;
  logic [3:0] temp_over_level;
  logic [11:0] digital_flags, adc_data, code_in;
  logic [4:0] adc_mux_sel;
  logic [16:0] last_res;
  logic [23:0] rd_q[$];
  logic [23:0] adc_q[$];
  logic [4:0] offs [8] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h1F};
  int fail_count, check_count, seed, n, k, busy_len;
  // ==========================================
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  dfm_core i_dut (.clk(clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .fault_line_mirror(fault_line_mirror), .status_word(status_word),
    .temp_over_level(temp_over_level), .ref_input_bad(ref_input_bad), .ref_output_bad(ref_output_bad),
    .regulator_bad(regulator_bad), .supply_bad(supply_bad), .open_circuit_fault(open_circuit_fault),
    .short_circuit_fault(short_circuit_fault), .digital_flags(digital_flags),
    .fault_line_n_i(fault_line_n), .fault_line_n_o(fault_line_n_o), .fault_line_n_oe(fault_line_n_oe),
    .adc_data(adc_data), .adc_start(adc_start), .adc_mux_sel(adc_mux_sel));
  dfm_far_model i_far (.dut_pull(fault_line_n_oe), .other_pull(other_pull), .fault_line_n(fault_line_n),
    .adc_mux_sel(adc_mux_sel), .code_in(code_in), .adc_data(adc_data));
  // ==========================================
  // Tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_rd_en = 1'b1;
    reg_rd_addr = a;
    rd_q.push_back({8'h00, e});
    @(negedge clk);
    reg_rd_en = 1'b0;
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic results();
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // Scoreboard: read data one edge after strobe, result when busy drops
  always @(posedge clk)
    rd_d <= reg_rd_en;
  always @(negedge clk)
  begin
    if (rd_d && rd_q.size() > 0)
      chk({8'h00, reg_rd_data}, rd_q.pop_front());
    if (status_word[17])
      busy_len++;
    else
    begin
      if (busy_d && adc_q.size() > 0)
      begin
        chk({7'h00, status_word[16:0]}, adc_q.pop_front());
        chk(24'(busy_len), 24'h0000FA);
      end
      busy_len = 0;
    end
    busy_d = status_word[17];
  end
  // ==========================================
  // Main sequence
  initial
  begin
    seed = 23;
    {nrst, reg_wr_en, reg_rd_en, ref_input_bad, ref_output_bad, regulator_bad, supply_bad} = 7'h00;
    {open_circuit_fault, short_circuit_fault, other_pull} = 3'h0;
    {reg_wr_addr, reg_rd_addr, reg_wr_data, temp_over_level, digital_flags, code_in} = 54'h0;
    idle(20);
    chk(status_word, 24'h800000);
    nrst = 1'b1;
    idle(3);
    for (k = 0; k < 8; k++)
      rd(offs[k], 16'h0000);
    // Trip level select, sticky clear, release
    for (k = 0; k < 4; k++)
    begin
      wr(5'h02, 16'(k));
      temp_over_level = ~(4'h1 << k);
      idle(3);
      rd(5'h06, 16'h0000);
      temp_over_level = 4'h1 << k;
      idle(3);
      chk(24'(fault_line_n_oe), 24'h000001);
      chk(24'(fault_line_mirror), 24'h000001);
      wr(5'h06, 16'h0004);
      rd(5'h06, 16'h0004);
      temp_over_level = 4'h0;
      wr(5'h06, 16'h0004);
      rd(5'h06, 16'h0000);
      idle(2);
      chk(24'(fault_line_n_oe), 24'h000000);
    end
    // Supply comparators: off, then on, then buffer powered
    {ref_input_bad, ref_output_bad, regulator_bad, supply_bad} = 4'hF;
    idle(3);
    rd(5'h06, 16'h0000);
    wr(5'h03, 16'h0001);
    idle(3);
    rd(5'h06, 16'h0068);
    wr(5'h05, 16'h0001);
    wr(5'h04, 16'h03FF);
    idle(3);
    rd(5'h06, 16'h0078);
    chk(24'(fault_line_n_oe), 24'h000001);
    chk(24'(status_word[19]), 24'h000001);
    rd(5'h04, 16'h03FF);
    {ref_input_bad, ref_output_bad, regulator_bad, supply_bad} = 4'h0;
    {open_circuit_fault, short_circuit_fault} = 2'h3;
    wr(5'h06, 16'h007F);
    idle(3);
    rd(5'h06, 16'h0003);
    chk(24'(fault_line_n_oe), 24'h000000);
    wr(5'h04, 16'h0000);
    idle(3);
    chk(24'(fault_line_n_oe), 24'h000001);
    {open_circuit_fault, short_circuit_fault} = 2'h0;
    wr(5'h06, 16'h0003);
    other_pull = 1'b1;
    idle(3);
    chk(24'(fault_line_mirror), 24'h000001);
    chk(24'(fault_line_n_oe), 24'h000000);
    chk(24'(status_word[19]), 24'h000000);
    other_pull = 1'b0;
    // Digital sources, unmasked then masked with quiet serial errors
    for (n = 0; n < 2; n++)
    begin
      wr(5'h04, (n != 0) ? 16'h007F : 16'h0000);
      wr(5'h02, (n != 0) ? 16'h0008 : 16'h0000);
      for (k = 0; k < 12; k++)
      begin
        digital_flags = 12'h001 << k;
        idle(4);
        chk(24'(fault_line_n_oe), 24'((n == 0) ? ((12'h7F9 >> k) & 12'h001) : 12'(k == 6)));
        chk(24'(status_word[20]), 24'(k != 11));
      end
      digital_flags = 12'h000;
    end
    // Every channel select code, each with a discarded start and a busy status read
    wr(5'h04, 16'h0000);
    last_res = 17'h00000;
    for (k = 0; k < 32; k++)
    begin
      code_in = 12'($random(seed));
      wr(5'h07, 16'h0400 | 16'(k));
      adc_q.push_back(24'({5'(k), code_in ^ {5'(k), 7'h00}}));
      wr(5'h07, 16'h0400 | 16'(5'(k) ^ 5'h1F));
      rd(5'h08, last_res[15:0]);
      n = 0;
      while (status_word[17] === 1'b1 && n < 400)
      begin
        @(negedge clk);
        n++;
      end
      if (n >= 400)
      begin
        fail_count++;
        results();
      end
      last_res = {5'(k), code_in ^ {5'(k), 7'h00}};
      idle(2);
    end
    wr(5'h07, 16'h0500);
    idle(3);
    chk(24'(status_word[17]), 24'h000000);
    rd(5'h07, 16'h0500);
    // Reset during a conversion
    wr(5'h07, 16'h0403);
    nrst = 1'b0;
    idle(2);
    chk(status_word, 24'h800000);
    nrst = 1'b1;
    idle(5);
    chk(24'(adc_q.size()), 24'h000000);
    results();
  end
endmodule
